/* rtl/fdc_defines.svh */
`ifndef FDC_DEFINES_SVH
`define FDC_DEFINES_SVH

// ----------------------------------------------------------------------
// Chain geometry defaults
// ----------------------------------------------------------------------
`define FDC_STAGES 2
`define FDC_STAGE_DEPTH 32768
`define FDC_WORD_WIDTH 18

// ----------------------------------------------------------------------
// Timing figures: clock periods in ns, delays in periods of the named clock
// ----------------------------------------------------------------------
`define FDC_CLK_PERIOD_NS 10
`define FDC_XFER_PERIOD_NS 10
`define FDC_XFER_DIV (`FDC_XFER_PERIOD_NS / `FDC_CLK_PERIOD_NS)
`define FDC_SPACE_XFER_PERIODS 3
`define FDC_SPACE_WRITE_PERIODS 2

`endif

/* rtl/fdc_pkg.sv */
package fdc_pkg;

    // ------------------------------------------------------------------
    // Timing mode picked up while master reset is held
    // ------------------------------------------------------------------
    typedef enum logic {
        FDC_STANDARD = 1'b0,
        FDC_FALL_THROUGH = 1'b1
    } fdc_mode_type;

endpackage : fdc_pkg

/* rtl/fdc_ram_if.sv */
`timescale 1ns/1ps

interface fdc_ram_if #(
    parameter int AW = 15,
    parameter int DW = 18
);
    logic we;
    logic [AW-1:0] waddr;
    logic [DW-1:0] wdata;
    logic [AW-1:0] raddr;
    logic [DW-1:0] rdata;

    modport ctrl (output we, output waddr, output wdata, output raddr,
                  input rdata);
    modport mem (input we, input waddr, input wdata, input raddr,
                 output rdata);
endinterface : fdc_ram_if

/* rtl/fdc_stage_ram.sv */
`timescale 1ns/1ps

module fdc_stage_ram #(
    parameter int AW = 15,
    parameter int DW = 18,
    parameter int DEPTH = 32768
) (
    input wire logic clk_i,
    fdc_ram_if.mem port
);

    logic [DW-1:0] mem [DEPTH];
    logic [DW-1:0] rdata;

    // Read data always come out of a register so the array maps to
    // block memory.
    always_ff @(posedge clk_i) begin
        if (port.we) begin
            mem[port.waddr] <= port.wdata;
        end
        rdata <= mem[port.raddr];
    end

    assign port.rdata = rdata;

endmodule : fdc_stage_ram

/* rtl/fifo_depth_expansion_chain.sv */
`timescale 1ns/1ps
`include "fdc_defines.svh"

module fifo_depth_expansion_chain #(
    parameter int STAGES = `FDC_STAGES,
    parameter int DEPTH = `FDC_STAGE_DEPTH,
    parameter int WIDTH = `FDC_WORD_WIDTH,
    parameter int XFER_DIV = `FDC_XFER_DIV
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic fall_through_timing_i,
    input wire logic wr_en_i,
    input wire logic [WIDTH-1:0] wr_data_i,
    input wire logic rd_en_i,
    output logic [WIDTH-1:0] rd_data_o,
    output logic output_valid_n_o,
    output logic space_available_flag_n_o,
    output logic fall_through_o
);

    // ------------------------------------------------------------------
    // Widths and limits
    // ------------------------------------------------------------------
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam int DVW = (XFER_DIV > 1) ? $clog2(XFER_DIV) : 1;
    localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);
    localparam logic [AW-1:0] LAST_ADDR = AW'(DEPTH - 1);
    localparam logic [DVW-1:0] LAST_DIV = DVW'(XFER_DIV - 1);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [1:0] mode_sync;
        fdc_pkg::fdc_mode_type mode;
        logic [DVW-1:0] div;
        logic [STAGES-1:0][CW-1:0] cnt;
        logic [STAGES-1:0][AW-1:0] wptr;
        logic [STAGES-1:0][AW-1:0] rptr;
        logic [STAGES-1:0] valid_n;
        logic [STAGES-1:0] space_n;
    } fdc_state_type;

    fdc_state_type st;
    fdc_state_type next_st;

    logic xfer_en;
    logic [STAGES-1:0] push;
    logic [STAGES-1:0] pop;
    logic [STAGES-1:0][AW-1:0] next_rptr;
    logic [STAGES-1:0][WIDTH-1:0] stage_rdata;

    // ------------------------------------------------------------------
    // Per-stage storage
    // ------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < STAGES; g++) begin : gen_stage
            fdc_ram_if #(.AW(AW), .DW(WIDTH)) ram ();

            // Stage data outputs feed the next stage directly.
            assign ram.we = push[g];
            assign ram.waddr = st.wptr[g];
            if (g == 0) begin : gen_head
                assign ram.wdata = wr_data_i;
            end else begin : gen_link
                assign ram.wdata = stage_rdata[g-1];
            end
            // Reading ahead at the next pointer keeps the head word on
            // the outputs without an explicit read.
            assign ram.raddr = next_rptr[g];
            assign stage_rdata[g] = ram.rdata;

            fdc_stage_ram #(
                .AW(AW),
                .DW(WIDTH),
                .DEPTH(DEPTH)
            ) u_ram (
                .clk_i(clk_i),
                .port(ram.mem)
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // Transfer enable
    // ------------------------------------------------------------------
    // One clock serves write, read and transfer sides, which is the
    // fastest choice; a larger divider models a slower transfer clock.
    assign xfer_en = (st.div == '0);

    // ------------------------------------------------------------------
    // Handshake between stages
    // ------------------------------------------------------------------
    always_comb begin
        logic in_req;
        in_req = 1'b0;
        push = '0;
        pop = '0;
        for (int s = 0; s < STAGES; s++) begin
            if (s == 0) begin
                // Writes are refused unless fall-through was chosen.
                in_req = wr_en_i && (st.mode == fdc_pkg::FDC_FALL_THROUGH);
            end else begin
                // Low valid of the previous stage is its next write.
                in_req = !st.valid_n[s-1] && xfer_en;
            end
            push[s] = in_req && !st.space_n[s];
        end
        for (int s = 0; s < STAGES; s++) begin
            if (s == STAGES - 1) begin
                pop[s] = rd_en_i && !st.valid_n[s];
            end else begin
                // Room downstream pulls one word out of this stage.
                pop[s] = push[s+1];
            end
        end
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        logic [CW-1:0] left;
        left = '0;
        next_st = st;
        next_rptr = st.rptr;
        next_st.mode_sync = {st.mode_sync[0], fall_through_timing_i};
        if (st.div == LAST_DIV) begin
            next_st.div = '0;
        end else begin
            next_st.div = st.div + DVW'(1);
        end
        for (int s = 0; s < STAGES; s++) begin
            if (pop[s]) begin
                next_rptr[s] = (st.rptr[s] == LAST_ADDR) ? '0
                             : st.rptr[s] + AW'(1);
            end
            if (push[s]) begin
                next_st.wptr[s] = (st.wptr[s] == LAST_ADDR) ? '0
                                : st.wptr[s] + AW'(1);
            end
            next_st.rptr[s] = next_rptr[s];
            left = st.cnt[s] - CW'(pop[s]);
            // Every stage holds its full depth, so the chain holds
            // the sum of them.
            next_st.cnt[s] = left + CW'(push[s]);
            // A word written into an empty stage lands in the array in
            // the same edge the array reads it, so it shows one edge
            // later; words behind it stream at full rate.
            next_st.valid_n[s] = (left == '0);
            next_st.space_n[s] = (next_st.cnt[s] == FULL_COUNT);
        end
        if (!nrst_i) begin
            next_st.mode = fdc_pkg::fdc_mode_type'(st.mode_sync[1]);
            next_st.div = '0;
            next_st.cnt = '0;
            next_st.wptr = '0;
            next_st.rptr = '0;
            next_st.valid_n = '1;
            next_st.space_n = '0;
            next_rptr = '0;
        end
    end

    always_ff @(posedge clk_i) begin
        st <= next_st;
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign rd_data_o = stage_rdata[STAGES-1];
    assign output_valid_n_o = st.valid_n[STAGES-1];
    assign space_available_flag_n_o = st.space_n[0];
    assign fall_through_o = st.mode;

endmodule : fifo_depth_expansion_chain

/* sim/fdc_props.sv */
`timescale 1ns/1ps
module fdc_props #(
    parameter int WIDTH = 18
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic fall_through_timing_i,
    input wire logic wr_en_i,
    input wire logic [WIDTH-1:0] wr_data_i,
    input wire logic rd_en_i,
    input wire logic [WIDTH-1:0] rd_data_o,
    input wire logic output_valid_n_o,
    input wire logic space_available_flag_n_o,
    input wire logic fall_through_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    property p_rst;
        $rose(nrst_i) |-> output_valid_n_o && !space_available_flag_n_o;
    endproperty
    a_rst: assert property (p_rst) else $error("flags after reset");
    property p_lat;
        $rose(nrst_i) |-> output_valid_n_o [*5];
    endproperty
    a_lat: assert property (p_lat) else $error("word too early");
    property p_mode;
        $past(nrst_i) |-> $stable(fall_through_o);
    endproperty
    a_mode: assert property (p_mode) else $error("mode moved");
    property p_std;
        !fall_through_o |-> output_valid_n_o;
    endproperty
    a_std: assert property (p_std) else $error("data in std mode");
    property p_hold;
        !output_valid_n_o && !rd_en_i |=>
            !output_valid_n_o && $stable(rd_data_o);
    endproperty
    a_hold: assert property (p_hold) else $error("head lost");
    property p_fell;
        $fell(output_valid_n_o) |-> fall_through_o;
    endproperty
    a_fell: assert property (p_fell) else $error("valid w/o mode");
    property p_full;
        $rose(space_available_flag_n_o) |-> $past(wr_en_i);
    endproperty
    a_full: assert property (p_full) else $error("full w/o write");
    property p_back;
        space_available_flag_n_o && rd_en_i && !output_valid_n_o |->
            ##[1:5] !space_available_flag_n_o;
    endproperty
    a_back: assert property (p_back) else $error("space late");
    c_fill: cover property ($rose(space_available_flag_n_o));
    c_word: cover property ($fell(output_valid_n_o));
    c_pop: cover property (space_available_flag_n_o && rd_en_i);
endmodule : fdc_props
bind fifo_depth_expansion_chain fdc_props #(.WIDTH(WIDTH)) i_fdc_props (
    .clk_i(clk_i), .nrst_i(nrst_i),
    .fall_through_timing_i(fall_through_timing_i), .wr_en_i(wr_en_i),
    .wr_data_i(wr_data_i), .rd_en_i(rd_en_i), .rd_data_o(rd_data_o),
    .output_valid_n_o(output_valid_n_o),
    .space_available_flag_n_o(space_available_flag_n_o),
    .fall_through_o(fall_through_o));

/* sim/fdc_reader.sv */
`timescale 1ns/1ps
// ---------------------------------------------------------
// Downstream reader
// ---------------------------------------------------------
module fdc_reader (
    input wire logic go_i,
    input wire logic valid_n_i,
    output logic rd_en_o
);
    // Pops at full rate so that any chain stall shows up.
    assign rd_en_o = go_i & ~valid_n_i;
endmodule : fdc_reader

/* sim/fifo_depth_expansion_chain_test.sv */
`timescale 1ns/1ps
module fifo_depth_expansion_chain_test;
    localparam int CAP = 8;
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic strap = 1'b1;
    logic wr_en_i = 1'b0;
    logic [17:0] wr_data_i = 18'h00000;
    logic go = 1'b0;
    logic rd_en_i;
    logic [17:0] rd_data_o;
    logic valid_n;
    logic space_n;
    logic ft;
    int mismatches = 0;
    int cmp_count = 0;
    int n;
    int k;
    int sp;
    int last;
    always #5 clk_i = ~clk_i;
    // Every stage shares one depth, as paralleled devices must.
    fifo_depth_expansion_chain #(.DEPTH(4)) i_fifo_depth_expansion_chain (
        .clk_i(clk_i), .nrst_i(nrst_i), .fall_through_timing_i(strap),
        .wr_en_i(wr_en_i), .wr_data_i(wr_data_i), .rd_en_i(rd_en_i),
        .rd_data_o(rd_data_o), .output_valid_n_o(valid_n),
        .space_available_flag_n_o(space_n), .fall_through_o(ft));
    fdc_reader i_fdc_reader (.go_i(go), .valid_n_i(valid_n),
        .rd_en_o(rd_en_i));
    task automatic check(string what, logic [17:0] seen, logic [17:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic close_out();
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : close_out
    task automatic do_reset(logic mode);
        strap <= mode;
        nrst_i <= 1'b0;
        repeat (6) @(posedge clk_i);
        nrst_i <= 1'b1;
        @(posedge clk_i);
        #1;
        check("mode", ft, mode);
        check("valid", valid_n, 1'b1);
        check("space", space_n, 1'b0);
    endtask : do_reset
    initial begin
        do_reset(1'b0);
        wr_en_i <= 1'b1;
        @(posedge clk_i);
        wr_en_i <= 1'b0;
        repeat (12) @(posedge clk_i);
        #1;
        check("std refuse", valid_n, 1'b1);
        $display("standard mode test done");
        do_reset(1'b1);
        wr_data_i <= 18'h2A5C3;
        wr_en_i <= 1'b1;
        @(posedge clk_i);
        wr_en_i <= 1'b0;
        n = 0;
        #1;
        while (valid_n !== 1'b0) begin
            if (n == 20) begin
                mismatches++;
                close_out();
            end
            @(posedge clk_i);
            #1;
            n++;
        end
        // One clock serves all sides, so no skew cycles are budgeted.
        // The word is taken at the write edge; each stage then needs
        // one edge to store and one to show it, minus the shared edge.
        check("latency", 18'(n), 18'h00003);
        check("first", rd_data_o, 18'h2A5C3);
        go <= 1'b1;
        @(posedge clk_i);
        go <= 1'b0;
        #1;
        check("empty", valid_n, 1'b1);
        $display("ripple test done");
        n = 0;
        for (int i = 0; i < 40; i++) begin
            // Drives only while room is shown, so every strobe is a word.
            wr_en_i <= (space_n === 1'b0);
            wr_data_i <= 18'(n);
            if (space_n === 1'b0) n++;
            @(posedge clk_i);
            #1;
        end
        wr_en_i <= 1'b0;
        check("capacity", 18'(n), 18'(CAP));
        check("full", space_n, 1'b1);
        $display("fill test done");
        go <= 1'b1;
        k = 0;
        sp = -1;
        last = -1;
        for (int i = 0; i < 30; i++) begin
            if (valid_n === 1'b0 && k < CAP) begin
                check("order", rd_data_o, 18'(k));
                k++;
                last = i;
            end
            if (space_n === 1'b0 && sp < 0) sp = i;
            @(posedge clk_i);
            #1;
        end
        go <= 1'b0;
        check("words", 18'(k), 18'(CAP));
        check("stream", 18'(last), 18'(CAP - 1));
        check("bubble", 18'(sp >= 1 && sp <= 5), 18'h00001);
        check("drained", valid_n, 1'b1);
        $display("drain test done");
        close_out();
    end
endmodule : fifo_depth_expansion_chain_test
